// ### qtb_pkg.sv
`default_nettype none
package qtb_pkg;
    localparam int QTB_DATA_W = 16;
    localparam int QTB_ADDR_W = 16;
    localparam int QTB_RAM_DEPTH = 256;
    localparam int QTB_RAM_AW = 8;
    localparam int QTB_COEF_W = 6;

    // Table window 0xb800 to 0xbbfc, one 16-bit entry per aligned word.
    localparam logic [5:0] QTB_TABLE_TAG = 6'h2e;
    localparam logic [15:0] QTB_TABLE_BASE = 16'hb800;
    localparam logic [15:0] QTB_TABLE_LAST = 16'hbbfc;

    localparam logic [15:0] QTB_OFF_BANK_SELECT = 16'hbc00;
    localparam logic [15:0] QTB_OFF_SYNC_CONTROL = 16'hbe00;
    localparam logic [15:0] QTB_OFF_LUMA_CHROMA_SEQ = 16'hbe08;
    localparam logic [15:0] QTB_OFF_BANK_SEQ = 16'hbe0c;

    localparam int QTB_BANK_SEL_BIT = 0;
    localparam int QTB_SYNC_TEST_LO_BIT = 8;
    localparam int QTB_SYNC_TEST_HI_BIT = 9;
    localparam int QTB_SYNC_FOUR_TABLE_BIT = 10;
    localparam int QTB_SYNC_DATA_LSB = 0;
    localparam int QTB_SYNC_DATA_W = 6;
    localparam int QTB_LC_SEQ_W = 14;
    localparam int QTB_BANK_SEQ_W = 8;

    localparam logic [15:0] QTB_BANK_SEL_MASK = 16'h0001;
    localparam logic [15:0] QTB_SYNC_MASK = 16'h073f;
    localparam logic [15:0] QTB_LC_SEQ_MASK = 16'h3fff;
    localparam logic [15:0] QTB_BANK_SEQ_MASK = 16'h00ff;

    localparam logic [15:0] QTB_RST_BANK_SELECT = 16'h0000;
    localparam logic [15:0] QTB_RST_SYNC = 16'h0000;
    localparam logic [15:0] QTB_RST_LC_SEQ = 16'h0000;
    localparam logic [15:0] QTB_RST_BANK_SEQ = 16'h0000;
    localparam logic [15:0] QTB_UNMAPPED_DATA = 16'h0000;

    // Physical half of the RAM: A tables low, B tables high.
    localparam logic QTB_HALF_A = 1'b0;
    localparam logic QTB_HALF_B = 1'b1;
    localparam logic QTB_SEL_A = 1'b1;
endpackage : qtb_pkg
`default_nettype wire

// ### qtb_mem_if.sv
`timescale 1ns/10ps
`default_nettype none
interface qtb_mem_if;
    import qtb_pkg::*;
    logic wr_en;
    logic [QTB_RAM_AW-1:0] wr_addr;
    logic [QTB_DATA_W-1:0] wr_data;
    logic hrd_en;
    logic [QTB_RAM_AW-1:0] hrd_addr;
    logic [QTB_DATA_W-1:0] hrd_data;
    logic [QTB_RAM_AW-1:0] qrd_addr;
    logic [QTB_DATA_W-1:0] qrd_data;

    modport ctrl (
        output wr_en, wr_addr, wr_data, hrd_en, hrd_addr, qrd_addr,
        input hrd_data, qrd_data
    );
    modport ram (
        input wr_en, wr_addr, wr_data, hrd_en, hrd_addr, qrd_addr,
        output hrd_data, qrd_data
    );
endinterface : qtb_mem_if
`default_nettype wire

// ### qtb_table_ram.sv
`timescale 1ns/10ps
`default_nettype none
module qtb_table_ram
    import qtb_pkg::*;
(
    input wire logic clk_i,
    qtb_mem_if.ram mem
);
    logic [QTB_DATA_W-1:0] table_mem [QTB_RAM_DEPTH];
    logic [QTB_DATA_W-1:0] hrd_pipe_ff;
    logic [QTB_DATA_W-1:0] qrd_data_ff;

    always_ff @(posedge clk_i)
    begin
        if (mem.wr_en)
        begin
            table_mem[mem.wr_addr] <= mem.wr_data;
        end
    end

    // Host side pipeline register; it only advances on a host table read.
    always_ff @(posedge clk_i)
    begin
        if (mem.hrd_en)
        begin
            hrd_pipe_ff <= table_mem[mem.hrd_addr];
        end
    end

    always_ff @(posedge clk_i)
    begin
        qrd_data_ff <= table_mem[mem.qrd_addr];
    end

    assign mem.hrd_data = hrd_pipe_ff;
    assign mem.qrd_data = qrd_data_ff;
endmodule : qtb_table_ram
`default_nettype wire

// ### qtb_bank_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module qtb_bank_ctrl
    import qtb_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic [QTB_ADDR_W-1:0] HOST_ADDR_I,
    input wire logic HOST_WR_I,
    input wire logic HOST_RD_I,
    input wire logic [QTB_DATA_W-1:0] HOST_DATA_I,
    output logic [QTB_DATA_W-1:0] HOST_DATA_O,
    input wire logic FRAME_SYNC_N_I,
    input wire logic START_I,
    input wire logic PARAM_UPDATE_GATE_I,
    input wire logic DEVICE_IDLE_I,
    input wire logic [1:0] QNT_TABLE_I,
    input wire logic [QTB_COEF_W-1:0] QNT_COEF_I,
    output logic [QTB_DATA_W-1:0] QNT_DATA_O,
    output logic QNT_ACTIVE_A_O,
    output logic QNT_FOUR_TABLE_O,
    output logic [QTB_LC_SEQ_W-1:0] QNT_LUMA_CHROMA_SEQ_O,
    output logic [QTB_BANK_SEQ_W-1:0] QNT_BANK_SEQ_O,
    output logic [QTB_SYNC_DATA_W-1:0] QNT_DATA_SYNC_O
);
    qtb_mem_if mem ();

    logic [QTB_DATA_W-1:0] bank_select_ff;
    logic [QTB_DATA_W-1:0] sync_control_ff;
    logic [QTB_DATA_W-1:0] luma_chroma_seq_ff;
    logic [QTB_DATA_W-1:0] bank_seq_ff;
    logic active_a_ff;
    logic fs_meta_ff;
    logic fs_sync_ff;
    logic fs_prev_ff;
    logic test_prev_ff;
    logic [QTB_DATA_W-1:0] host_data_ff;

    logic table_hit;
    logic four_table;
    logic host_half;
    logic quant_half;
    logic frame_sync_fall;
    logic test_sync_level;
    logic test_sync_fall;
    logic switch_evt;
    logic [QTB_RAM_AW-1:0] host_index;
    logic [QTB_RAM_AW-1:0] nxt_host_phys;
    logic [QTB_RAM_AW-1:0] nxt_quant_phys;
    logic [QTB_DATA_W-1:0] nxt_reg_rdata;

    qtb_table_ram u_table_ram (
        .clk_i(MCLK_I),
        .mem(mem.ram)
    );

    // Address decode of the table window; the two low address bits are don't-care.
    assign table_hit = (HOST_ADDR_I[15:10] == QTB_TABLE_TAG);
    assign host_index = HOST_ADDR_I[QTB_RAM_AW+1:2];
    assign four_table = sync_control_ff[QTB_SYNC_FOUR_TABLE_BIT];

    // In double-buffer mode the host always sees the half the quantizer is not
    // using, so a load can never land in the active set whatever address is used.
    assign host_half = active_a_ff ? QTB_HALF_B : QTB_HALF_A;
    assign quant_half = active_a_ff ? QTB_HALF_A : QTB_HALF_B;

    always_comb
    begin
        if (four_table)
        begin
            nxt_host_phys = host_index;
        end
        else
        begin
            nxt_host_phys = {host_half, host_index[QTB_RAM_AW-2:0]};
        end
    end

    // Four-table mode: table number picks one of four 64-entry tables and the
    // selector is ignored. Double-buffer: the low table bit picks luma or chroma.
    always_comb
    begin
        if (four_table)
        begin
            nxt_quant_phys = {QNT_TABLE_I, QNT_COEF_I};
        end
        else
        begin
            nxt_quant_phys = {quant_half, QNT_TABLE_I[0], QNT_COEF_I};
        end
    end

    assign mem.wr_en = HOST_WR_I & table_hit;
    assign mem.wr_addr = nxt_host_phys;
    assign mem.wr_data = HOST_DATA_I;
    assign mem.hrd_en = HOST_RD_I & table_hit;
    assign mem.hrd_addr = nxt_host_phys;
    assign mem.qrd_addr = nxt_quant_phys;

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            bank_select_ff <= QTB_RST_BANK_SELECT;
        end
        else if (HOST_WR_I && HOST_ADDR_I == QTB_OFF_BANK_SELECT)
        begin
            bank_select_ff <= HOST_DATA_I & QTB_BANK_SEL_MASK;
        end
    end

    // Reserved bits are not stored, so they read back as zero.
    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            sync_control_ff <= QTB_RST_SYNC;
        end
        else if (HOST_WR_I && HOST_ADDR_I == QTB_OFF_SYNC_CONTROL)
        begin
            sync_control_ff <= HOST_DATA_I & QTB_SYNC_MASK;
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            luma_chroma_seq_ff <= QTB_RST_LC_SEQ;
        end
        else if (HOST_WR_I && HOST_ADDR_I == QTB_OFF_LUMA_CHROMA_SEQ)
        begin
            luma_chroma_seq_ff <= HOST_DATA_I & QTB_LC_SEQ_MASK;
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            bank_seq_ff <= QTB_RST_BANK_SEQ;
        end
        else if (HOST_WR_I && HOST_ADDR_I == QTB_OFF_BANK_SEQ)
        begin
            bank_seq_ff <= HOST_DATA_I & QTB_BANK_SEQ_MASK;
        end
    end

    // Frame sync arrives from a pin and is synchronised before edge detection.
    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            fs_meta_ff <= 1'b1;
            fs_sync_ff <= 1'b1;
            fs_prev_ff <= 1'b1;
        end
        else
        begin
            fs_meta_ff <= FRAME_SYNC_N_I;
            fs_sync_ff <= fs_meta_ff;
            fs_prev_ff <= fs_sync_ff;
        end
    end

    assign frame_sync_fall = fs_prev_ff & ~fs_sync_ff;

    // Either test sync bit acts; the switch fires when the pair returns to zero.
    assign test_sync_level = sync_control_ff[QTB_SYNC_TEST_LO_BIT]
        | sync_control_ff[QTB_SYNC_TEST_HI_BIT];

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            test_prev_ff <= 1'b0;
        end
        else
        begin
            test_prev_ff <= test_sync_level;
        end
    end

    // The test strobe is honoured only while the device reports idle, since a
    // swap in mid-frame would hand the quantizer a half-loaded table set.
    assign test_sync_fall = test_prev_ff & ~test_sync_level & DEVICE_IDLE_I;
    assign switch_evt = (frame_sync_fall & START_I & PARAM_UPDATE_GATE_I)
        | test_sync_fall;

    // The internal selector follows the written value only on a switch event,
    // so the old set stays in use and protected until then.
    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            active_a_ff <= ~QTB_SEL_A;
        end
        else if (switch_evt)
        begin
            active_a_ff <= (bank_select_ff[QTB_BANK_SEL_BIT] == QTB_SEL_A);
        end
    end

    always_comb
    begin
        case (HOST_ADDR_I)
            QTB_OFF_BANK_SELECT: nxt_reg_rdata = bank_select_ff;
            QTB_OFF_SYNC_CONTROL: nxt_reg_rdata = sync_control_ff;
            QTB_OFF_LUMA_CHROMA_SEQ: nxt_reg_rdata = luma_chroma_seq_ff;
            QTB_OFF_BANK_SEQ: nxt_reg_rdata = bank_seq_ff;
            default: nxt_reg_rdata = QTB_UNMAPPED_DATA;
        endcase
    end

    // A table read returns the word fetched by the previous table read, which
    // is why software must read twice before the first valid word appears.
    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            host_data_ff <= QTB_UNMAPPED_DATA;
        end
        else if (HOST_RD_I)
        begin
            if (table_hit)
            begin
                host_data_ff <= mem.hrd_data;
            end
            else
            begin
                host_data_ff <= nxt_reg_rdata;
            end
        end
    end

    assign HOST_DATA_O = host_data_ff;
    assign QNT_DATA_O = mem.qrd_data;
    assign QNT_ACTIVE_A_O = active_a_ff;
    assign QNT_FOUR_TABLE_O = four_table;
    assign QNT_LUMA_CHROMA_SEQ_O = luma_chroma_seq_ff[QTB_LC_SEQ_W-1:0];
    assign QNT_BANK_SEQ_O = bank_seq_ff[QTB_BANK_SEQ_W-1:0];
    assign QNT_DATA_SYNC_O = sync_control_ff[QTB_SYNC_DATA_LSB +: QTB_SYNC_DATA_W];
endmodule : qtb_bank_ctrl
`default_nettype wire

// ### qtb_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module qtb_host_model
    import qtb_pkg::*;
(
    input wire logic clk_i,
    output logic [QTB_ADDR_W-1:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [QTB_DATA_W-1:0] data_o
);
    initial
    begin
        addr_o = 16'h0000;
        data_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // The strobe stays up after return, so back-to-back calls give one access per cycle.
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(negedge clk_i);
        addr_o = a;
        data_o = d;
        wr_o = w;
        rd_o = !w;
        @(posedge clk_i);
    endtask : access

    // A released bus shows the inverse of its last value, not a stale copy.
    task automatic idle();
        @(negedge clk_i);
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = ~addr_o;
        data_o = ~data_o;
    endtask : idle
endmodule : qtb_host_model
`default_nettype wire

// ### qtb_props.sv
`timescale 1ns/10ps
`default_nettype none
module qtb_props
    import qtb_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic [QTB_ADDR_W-1:0] HOST_ADDR_I,
    input wire logic HOST_WR_I,
    input wire logic HOST_RD_I,
    input wire logic [QTB_DATA_W-1:0] HOST_DATA_I,
    input wire logic [QTB_DATA_W-1:0] HOST_DATA_O,
    input wire logic FRAME_SYNC_N_I,
    input wire logic START_I,
    input wire logic PARAM_UPDATE_GATE_I,
    input wire logic DEVICE_IDLE_I,
    input wire logic QNT_ACTIVE_A_O,
    input wire logic QNT_FOUR_TABLE_O,
    input wire logic [QTB_LC_SEQ_W-1:0] QNT_LUMA_CHROMA_SEQ_O,
    input wire logic [QTB_BANK_SEQ_W-1:0] QNT_BANK_SEQ_O
);
    logic bank_ff;
    logic [1:0] tst_ff;
    logic wr_sync;
    logic tsync_evt;
    assign wr_sync = HOST_WR_I && HOST_ADDR_I == QTB_OFF_SYNC_CONTROL;
    assign tsync_evt = wr_sync && HOST_DATA_I[9:8] == 2'h0 && tst_ff != 2'h0 && DEVICE_IDLE_I;

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            bank_ff <= 1'b0;
            tst_ff <= 2'h0;
        end
        else
        begin
            if (HOST_WR_I && HOST_ADDR_I == QTB_OFF_BANK_SELECT)
                bank_ff <= HOST_DATA_I[0];
            if (wr_sync)
                tst_ff <= HOST_DATA_I[9:8];
        end
    end

    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);

    sequence s_fs_fall;
        FRAME_SYNC_N_I ##1 (!FRAME_SYNC_N_I && START_I && PARAM_UPDATE_GATE_I);
    endsequence
    property p_rst_b;
        $fell(RST_I) |-> !QNT_ACTIVE_A_O;
    endproperty
    property p_frame;
        s_fs_fall |-> ##4 QNT_ACTIVE_A_O == bank_ff;
    endproperty
    property p_tsync;
        tsync_evt |-> ##3 QNT_ACTIVE_A_O == bank_ff;
    endproperty
    property p_only_evt;
        $changed(QNT_ACTIVE_A_O) |-> $past(tsync_evt, 3) || $past(tsync_evt, 2)
            || ($past(START_I) && $past(PARAM_UPDATE_GATE_I) && !$past(FRAME_SYNC_N_I, 3));
    endproperty
    property p_four;
        wr_sync |=> QNT_FOUR_TABLE_O == $past(HOST_DATA_I[10]);
    endproperty
    property p_lc;
        HOST_WR_I && HOST_ADDR_I == QTB_OFF_LUMA_CHROMA_SEQ
            |=> QNT_LUMA_CHROMA_SEQ_O == $past(HOST_DATA_I[13:0]);
    endproperty
    property p_abs;
        HOST_WR_I && HOST_ADDR_I == QTB_OFF_BANK_SEQ |=> QNT_BANK_SEQ_O == $past(HOST_DATA_I[7:0]);
    endproperty
    property p_hold;
        !HOST_RD_I |=> $stable(HOST_DATA_O);
    endproperty

    a_rst_b: assert property (p_rst_b) else $error("selector not on B after reset");
    a_frame: assert property (p_frame) else $error("frame sync did not load select");
    a_tsync: assert property (p_tsync) else $error("test sync did not load select");
    a_only_evt: assert property (p_only_evt) else $error("selector moved without event");
    a_four: assert property (p_four) else $error("table organisation wrong");
    a_lc: assert property (p_lc) else $error("luma chroma sequence wrong");
    a_abs: assert property (p_abs) else $error("bank sequence wrong");
    a_hold: assert property (p_hold) else $error("read data moved without read");
endmodule : qtb_props

bind qtb_bank_ctrl qtb_props qtb_props_inst (.*);
`default_nettype wire

// ### test_quantizer_table_bank_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_quantizer_table_bank_control
    import qtb_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [15:0] din;
    logic [15:0] dout;
    logic fs_n = 1'b1;
    logic dev_idle = 1'b1;
    logic four;
    logic [5:0] dsync;
    logic [13:0] lcs;
    logic [7:0] bseq;
    logic [15:0] wv[5];
    logic start = 1'b0;
    logic gate = 1'b1;
    logic [1:0] tbl = 2'h0;
    logic [5:0] coef = 6'h00;
    logic [15:0] qdata;
    logic act;
    logic rd_p = 1'b0;
    logic [16:0] expq[$];
    logic [16:0] e;
    logic [15:0] mem[256];
    logic [15:0] ra[5] = '{16'hbc00, 16'hbe00, 16'hbe08, 16'hbe0c, 16'hbe04};
    logic [15:0] rm[5] = '{16'h0001, 16'h073f, 16'h3fff, 16'h00ff, 16'h0000};
    logic [15:0] d;
    logic [7:0] k;
    logic [7:0] n;
    int error_cnt = 0;
    int tests_run = 0;
    int i;

    always #2.5 mclk = ~mclk;

    qtb_host_model qtb_host_model_inst (.clk_i(mclk), .addr_o(addr), .wr_o(wr), .rd_o(rd),
        .data_o(din));
    qtb_bank_ctrl qtb_bank_ctrl_inst (.MCLK_I(mclk), .RST_I(rst), .HOST_ADDR_I(addr),
        .HOST_WR_I(wr), .HOST_RD_I(rd), .HOST_DATA_I(din), .HOST_DATA_O(dout),
        .FRAME_SYNC_N_I(fs_n), .START_I(start), .PARAM_UPDATE_GATE_I(gate),
        .DEVICE_IDLE_I(dev_idle), .QNT_TABLE_I(tbl), .QNT_COEF_I(coef), .QNT_DATA_O(qdata),
        .QNT_ACTIVE_A_O(act), .QNT_FOUR_TABLE_O(four), .QNT_LUMA_CHROMA_SEQ_O(lcs),
        .QNT_BANK_SEQ_O(bseq), .QNT_DATA_SYNC_O(dsync));

    task automatic check(input string nm, input logic [15:0] x, input logic [15:0] g);
        tests_run++;
        if (g !== x)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    task automatic wreg(input logic [15:0] a, input logic [15:0] v);
        qtb_host_model_inst.access(1'b1, a, v);
    endtask : wreg

    // Bit 16 of a note marks a word that the read pipeline leaves undefined.
    task automatic rreg(input logic [15:0] a, input logic [16:0] x);
        expq.push_back(x);
        qtb_host_model_inst.access(1'b0, a, 16'h0000);
    endtask : rreg

    task automatic qchk(input logic [1:0] t, input logic [5:0] c, input logic [15:0] x);
        @(negedge mclk);
        tbl = t;
        coef = c;
        @(negedge mclk);
        check("qnt_data", x, qdata);
    endtask : qchk

    task automatic fsync(input logic s);
        qtb_host_model_inst.idle();
        start = s;
        fs_n = 1'b0;
        repeat (4) @(negedge mclk);
        fs_n = 1'b1;
        repeat (4) @(negedge mclk);
        start = 1'b0;
    endtask : fsync

    always @(posedge mclk)
        rd_p <= rd && !rst;

    always @(negedge mclk)
    begin
        if (rd_p && expq.size() > 0)
        begin
            e = expq.pop_front();
            if (!e[16])
                check("host_data", e[15:0], dout);
        end
    end

    initial
    begin
        #100000;
        error_cnt++;
        end_sim();
    end

    initial
    begin
        void'($urandom(32'h66973ac3));
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        check("active", 16'h0000, {15'h0, act});
        for (i = 0; i < 5; i++)
            rreg(ra[i], 17'h00000);
        for (i = 0; i < 5; i++)
        begin
            d = 16'($urandom()) & 16'hfcff;
            wv[i] = d & rm[i];
            wreg(ra[i], d);
            rreg(ra[i], {1'b0, d & rm[i]});
        end
        wreg(QTB_OFF_SYNC_CONTROL, 16'h043e);
        @(negedge mclk);
        check("four_table", 16'h0001, {15'h0, four});
        check("data_sync", 16'h003e, {10'h0, dsync});
        check("lc_seq", {2'h0, wv[2][13:0]}, {2'h0, lcs});
        check("bank_seq", {8'h0, wv[3][7:0]}, {8'h0, bseq});
        for (i = 0; i < 256; i++)
        begin
            mem[i] = 16'($urandom());
            wreg(16'hb800 + 16'(i * 4), mem[i]);
        end
        k = 8'h00;
        rreg(16'hb800, 17'h10000);
        for (i = 0; i < 12; i++)
        begin
            n = 8'($urandom());
            rreg({6'h2e, n, 2'h0}, {1'b0, mem[k]});
            k = n;
        end
        for (i = 0; i < 12; i++)
        begin
            k = 8'($urandom());
            qchk(k[7:6], k[5:0], mem[k]);
        end
        wreg(QTB_OFF_SYNC_CONTROL, 16'h0000);
        for (i = 0; i < 8; i++)
        begin
            n = 8'($urandom());
            d = 16'($urandom());
            wreg({6'h2e, n, 2'h0}, d);
            mem[{1'b0, n[6:0]}] = d;
        end
        qtb_host_model_inst.idle();
        for (i = 0; i < 6; i++)
        begin
            n = 8'($urandom());
            qchk(n[7:6], n[5:0], mem[{1'b1, n[6:0]}]);
        end
        wreg(QTB_OFF_BANK_SELECT, 16'h0001);
        fsync(1'b0);
        check("active", 16'h0000, {15'h0, act});
        gate = 1'b0;
        fsync(1'b1);
        check("active", 16'h0000, {15'h0, act});
        gate = 1'b1;
        fsync(1'b1);
        check("active", 16'h0001, {15'h0, act});
        n = 8'($urandom()) & 8'h7f;
        qchk({1'b0, n[6]}, n[5:0], mem[{1'b0, n[6:0]}]);
        d = 16'($urandom());
        wreg({6'h2e, n, 2'h0}, d);
        mem[{1'b1, n[6:0]}] = d;
        rreg({6'h2e, n, 2'h0}, 17'h10000);
        rreg({6'h2e, n, 2'h0}, {1'b0, d});
        qtb_host_model_inst.idle();
        qchk({1'b0, n[6]}, n[5:0], mem[{1'b0, n[6:0]}]);
        wreg(QTB_OFF_SYNC_CONTROL, 16'h0400);
        qtb_host_model_inst.idle();
        qchk(2'h2, n[5:0], mem[{2'h2, n[5:0]}]);
        wreg(QTB_OFF_SYNC_CONTROL, 16'h0000);
        wreg(QTB_OFF_BANK_SELECT, 16'h0000);
        wreg(QTB_OFF_SYNC_CONTROL, 16'h0100);
        wreg(QTB_OFF_SYNC_CONTROL, 16'h0000);
        qtb_host_model_inst.idle();
        repeat (3) @(negedge mclk);
        check("active", 16'h0000, {15'h0, act});
        // A test strobe while the device is busy must leave the selector alone.
        dev_idle = 1'b0;
        wreg(QTB_OFF_BANK_SELECT, 16'h0001);
        wreg(QTB_OFF_SYNC_CONTROL, 16'h0200);
        wreg(QTB_OFF_SYNC_CONTROL, 16'h0000);
        qtb_host_model_inst.idle();
        repeat (3) @(negedge mclk);
        check("active", 16'h0000, {15'h0, act});
        dev_idle = 1'b1;
        end_sim();
    end
endmodule : test_quantizer_table_bank_control
`default_nettype wire
